/* File: irbm_pkg.sv */
// Shared constants and types for the IR burst modulator and lockup guard
package irbm_pkg;
    localparam int         IRBM_TIME_W       = 8;
    localparam int         IRBM_COUNT_W      = 10;
    localparam int         IRBM_COUNT_LO_W   = 8;
    localparam int         IRBM_COUNT_HI_W   = 2;
    localparam int         IRBM_PHASE_EXTRA  = 2;
    localparam int         IRBM_GUARD_STAGES = 17;
    localparam int         IRBM_GUARD_DIV    = 30;
    localparam logic [7:0] IRBM_DONE_VECTOR  = 8'h05;
    localparam logic [9:0] IRBM_TIMER_RESET  = 10'h000;
    localparam logic [1:0] IRBM_CARRIER_INIT = 2'h0;

    typedef enum logic [1:0] {
        IRBM_IDLE,
        IRBM_ON,
        IRBM_OFF
    } irbm_state_type;

    // Control bits written by the core
    typedef struct packed {
        logic continuousBit;
        logic longPulseBit;
        logic carrierBit;
    } irbm_mode_type;
endpackage

/* File: irbm_lockup_guard.sv */
// Lockup guard counter: divided clock, reload, stop hold, overflow reset
`timescale 1ns/1ps
module irbm_lockup_guard
    import irbm_pkg::*;
#(
    parameter int DIV    = IRBM_GUARD_DIV,
    parameter int STAGES = IRBM_GUARD_STAGES
) (
    input  wire logic clk_sys,
    input  wire logic reset,
    input  wire logic watchdogReloadBit,
    input  wire logic stopMode,
    output logic      guardReset
);
    logic [5:0]        divCount_q, divCount_d;
    logic [STAGES-1:0] guardCount_q, guardCount_d;
    logic              guardReset_q, guardReset_d;
    logic              tick;

    assign tick = (divCount_q == 6'(DIV - 1));

    always_comb begin
        divCount_d   = divCount_q;
        guardCount_d = guardCount_q;
        guardReset_d = 1'b0;
        if (watchdogReloadBit) begin
            guardCount_d = '0;
            divCount_d   = '0;
        end else if (!stopMode) begin
            divCount_d = tick ? 6'h00 : divCount_q + 6'h01;
            if (tick) begin
                guardCount_d = guardCount_q + 1'b1;
                guardReset_d = &guardCount_q;
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            divCount_q   <= '0;
            guardCount_q <= '0;
            guardReset_q <= 1'b0;
        end else begin
            divCount_q   <= divCount_d;
            guardCount_q <= guardCount_d;
            guardReset_q <= guardReset_d;
        end
    end

    assign guardReset = guardReset_q;

    a_guard_stop_hold: assert property (
        @(posedge clk_sys) disable iff (reset)
        stopMode && !watchdogReloadBit |=> $stable(guardCount_q))
        else $error("guard count moved in stop");
    a_guard_reload_clear: assert property (
        @(posedge clk_sys) disable iff (reset)
        watchdogReloadBit |=> guardCount_q == '0)
        else $error("reload did not clear guard");
    a_guard_tick_step: assert property (
        @(posedge clk_sys) disable iff (reset)
        !watchdogReloadBit && !stopMode && tick |=> guardCount_q == $past(guardCount_q) + 1'b1)
        else $error("guard count failed to step");
    a_guard_overflow_reset: assert property (
        @(posedge clk_sys) disable iff (reset)
        guardReset |-> guardCount_q == '0 && $past(tick) && $past(&guardCount_q))
        else $error("guard reset without overflow");
endmodule

/* File: irbm_modulator.sv */
// IR burst modulator with done interrupt and lockup guard
`timescale 1ns/1ps

// How it works
// - A burst starts only when the pulse count is written.
// - Burst start drives output low and loads the on-time into the timer.
// - Timer end in on phase releases output and decrements remaining count.
// - Pulses left: load off-time, count down, then restart on phase.
// - Count reaching zero raises the modulator-done interrupt request.
// - Rewriting only the count restarts a burst with stored timings.
// - Done request clears on count write or interrupt-clear bit write.
// - The done interrupt has its own vector address.
// - Lockup guard: seventeen stage counter clocked at oscillator over thirty.
// - Writing the reload bit clears the guard counter; nothing is stored.
// - Guard starts at zero after reset and steps every thirty cycles.
// - Guard overflow resets the whole device.
// - Idle mode keeps the guard counting.
// - Stop mode freezes the guard and keeps its count.
// - Each on and off phase lasts stored value plus two cycles.
// - Pulse count is ten bits, low eight and high two; never zero.
// - Continuous mode ignores the count and runs on and off forever.
// - Long pulse skips off phases; carrier chops on phases at quarter rate.
module irbm_modulator
    import irbm_pkg::*;
#(
    parameter int TIME_W       = IRBM_TIME_W,
    parameter int COUNT_W      = IRBM_COUNT_W,
    parameter int GUARD_STAGES = IRBM_GUARD_STAGES
) (
    input  wire logic                       clk_sys,
    input  wire logic                       reset,
    input  wire logic [TIME_W-1:0]          onTime,
    input  wire logic [TIME_W-1:0]          offTime,
    input  wire logic [IRBM_COUNT_LO_W-1:0] pulseCountLow,
    input  wire logic [IRBM_COUNT_HI_W-1:0] pulseCountHigh,
    input  wire logic                       pulseCountWrite,
    input  wire irbm_mode_type              mode,
    input  wire logic                       interruptClearBit,
    input  wire logic                       watchdogReloadBit,
    input  wire logic                       stopMode,
    output logic                            pulseOut_n,
    output logic                            modDoneIrq,
    output logic [7:0]                      modDoneVector,
    output logic                            guardReset
);
    irbm_state_type     state_q, state_d;
    logic [TIME_W:0]    timer_q, timer_d;
    logic [COUNT_W-1:0] remain_q, remain_d;
    logic               irq_q, irq_d;
    logic [1:0]         carrier_q, carrier_d;
    logic               outLow_q, outLow_d;
    logic               timerDone;
    logic               lastPulse;

    // Phase length minus one, so a value of v gives v+2 cycles
    function automatic logic [TIME_W:0] phaseLoad(input logic [TIME_W-1:0] v);
        phaseLoad = {1'b0, v} + (TIME_W+1)'(IRBM_PHASE_EXTRA - 1);
    endfunction

    assign timerDone = (timer_q == '0);
    assign lastPulse = (remain_q == COUNT_W'(1)) && !mode.continuousBit;

    always_comb begin
        state_d   = state_q;
        timer_d   = timer_q;
        remain_d  = remain_q;
        irq_d     = irq_q;
        carrier_d = carrier_q + 2'h1;
        if (interruptClearBit) begin
            irq_d = 1'b0;
        end
        if (pulseCountWrite) begin
            remain_d  = {pulseCountHigh, pulseCountLow};
            timer_d   = phaseLoad(onTime);
            state_d   = IRBM_ON;
            irq_d     = 1'b0;
            carrier_d = IRBM_CARRIER_INIT;
        end else begin
            unique case (state_q)
                IRBM_IDLE: begin
                    timer_d = '0;
                end
                IRBM_ON: begin
                    if (!timerDone) begin
                        timer_d = timer_q - 1'b1;
                    end else begin
                        if (!mode.continuousBit) begin
                            remain_d = remain_q - 1'b1;
                        end
                        if (lastPulse) begin
                            state_d = IRBM_IDLE;
                            irq_d   = 1'b1;
                        end else if (mode.longPulseBit) begin
                            timer_d = phaseLoad(onTime);
                        end else begin
                            timer_d = phaseLoad(offTime);
                            state_d = IRBM_OFF;
                        end
                    end
                end
                IRBM_OFF: begin
                    if (!timerDone) begin
                        timer_d = timer_q - 1'b1;
                    end else begin
                        timer_d   = phaseLoad(onTime);
                        state_d   = IRBM_ON;
                        carrier_d = IRBM_CARRIER_INIT;
                    end
                end
            endcase
        end
        // Output low when on phase active, chopped by carrier
        outLow_d = (state_d == IRBM_ON) &&
                   (!mode.carrierBit || !carrier_d[1]);
    end

    always_ff @(posedge clk_sys) begin
        if (reset || guardReset) begin
            state_q   <= IRBM_IDLE;
            timer_q   <= '0;
            remain_q  <= IRBM_TIMER_RESET;
            irq_q     <= 1'b0;
            carrier_q <= IRBM_CARRIER_INIT;
            outLow_q  <= 1'b0;
        end else begin
            state_q   <= state_d;
            timer_q   <= timer_d;
            remain_q  <= remain_d;
            irq_q     <= irq_d;
            carrier_q <= carrier_d;
            outLow_q  <= outLow_d;
        end
    end

    assign pulseOut_n    = !outLow_q;
    assign modDoneIrq    = irq_q;
    assign modDoneVector = IRBM_DONE_VECTOR;

    irbm_lockup_guard #(.DIV(IRBM_GUARD_DIV), .STAGES(GUARD_STAGES)) u_guard (
        .clk_sys           (clk_sys),
        .reset             (reset),
        .watchdogReloadBit (watchdogReloadBit),
        .stopMode          (stopMode),
        .guardReset        (guardReset)
    );

    // Burst sequencing checks
    a_start_drives_low: assert property (
        @(posedge clk_sys) disable iff (reset || guardReset)
        pulseCountWrite && !mode.carrierBit |=> !pulseOut_n)
        else $error("burst did not start on count write");

    a_idle_holds: assert property (
        @(posedge clk_sys) disable iff (reset || guardReset)
        state_q == IRBM_IDLE && !pulseCountWrite |=> state_q == IRBM_IDLE)
        else $error("burst started without count write");

    a_idle_output_high: assert property (
        @(posedge clk_sys) disable iff (reset || guardReset)
        state_q == IRBM_IDLE |-> pulseOut_n)
        else $error("output low while idle");

    a_write_loads_count: assert property (
        @(posedge clk_sys) disable iff (reset || guardReset)
        pulseCountWrite |=> remain_q == $past({pulseCountHigh, pulseCountLow}))
        else $error("count write not captured");

    a_on_phase_length: assert property (
        @(posedge clk_sys) disable iff (reset || guardReset)
        pulseCountWrite && onTime == 8'h01 && !mode.carrierBit && !mode.longPulseBit
        ##1 !pulseCountWrite [*3]
        |-> $past(!pulseOut_n, 2) && $past(!pulseOut_n) && !pulseOut_n ##1 pulseOut_n)
        else $error("on phase not value plus two");

    a_count_decrement: assert property (
        @(posedge clk_sys) disable iff (reset || guardReset)
        state_q == IRBM_ON && timerDone && !mode.continuousBit && !pulseCountWrite
        |=> remain_q == $past(remain_q) - 1'b1)
        else $error("remaining count not decremented");

    a_off_entry: assert property (
        @(posedge clk_sys) disable iff (reset || guardReset)
        state_q == IRBM_ON && timerDone && !lastPulse && !mode.longPulseBit && !pulseCountWrite
        |=> state_q == IRBM_OFF && pulseOut_n && timer_q == phaseLoad($past(offTime)))
        else $error("on phase end did not load off-time");

    a_off_reloads_on: assert property (
        @(posedge clk_sys) disable iff (reset || guardReset)
        state_q == IRBM_OFF && timerDone && !pulseCountWrite
        |=> state_q == IRBM_ON && timer_q == phaseLoad($past(onTime)))
        else $error("off phase end did not reload on-time");

    a_done_sets_irq: assert property (
        @(posedge clk_sys) disable iff (reset || guardReset)
        state_q == IRBM_ON && timerDone && lastPulse && !pulseCountWrite |=> modDoneIrq)
        else $error("done irq missing at burst end");

    a_irq_sticky: assert property (
        @(posedge clk_sys) disable iff (reset || guardReset)
        modDoneIrq && !pulseCountWrite && !interruptClearBit |=> modDoneIrq)
        else $error("done irq dropped without clear");

    a_irq_clear: assert property (
        @(posedge clk_sys) disable iff (reset || guardReset)
        pulseCountWrite || (interruptClearBit && !(state_q == IRBM_ON && timerDone && lastPulse))
        |=> !modDoneIrq)
        else $error("done irq not cleared");

    a_continuous_endless: assert property (
        @(posedge clk_sys) disable iff (reset || guardReset)
        mode.continuousBit && state_q != IRBM_IDLE && !pulseCountWrite |=> state_q != IRBM_IDLE)
        else $error("continuous train stopped");

    a_long_repeats_on: assert property (
        @(posedge clk_sys) disable iff (reset || guardReset)
        state_q == IRBM_ON && timerDone && !lastPulse && mode.longPulseBit && !pulseCountWrite
        |=> state_q == IRBM_ON && timer_q == phaseLoad($past(onTime)))
        else $error("long pulse did not extend on phase");

    a_carrier_chop: assert property (
        @(posedge clk_sys) disable iff (reset || guardReset)
        state_q == IRBM_ON |-> pulseOut_n == ($past(mode.carrierBit) && carrier_q[1]))
        else $error("carrier chopping wrong in on phase");
endmodule

/* File: irbm_core_model.sv */
// Core model driving timing, count, mode and control strobes
`timescale 1ns/1ps
module irbm_core_model
    import irbm_pkg::*;
(
    input  wire logic               clk_sys,
    output logic [IRBM_TIME_W-1:0]  onTime,
    output logic [IRBM_TIME_W-1:0]  offTime,
    output logic [IRBM_COUNT_W-1:0] pulseCount,
    output logic                    pulseCountWrite,
    output irbm_mode_type           mode,
    output logic                    interruptClearBit,
    output logic                    watchdogReloadBit,
    output logic                    stopMode
);
    initial begin
        {onTime, offTime, pulseCount} = 26'h0000001;
        {pulseCountWrite, interruptClearBit, watchdogReloadBit, stopMode} = 4'h0;
        mode = irbm_mode_type'(3'h0);
    end
    task automatic load_count(input logic [IRBM_COUNT_W-1:0] cnt);
        @(negedge clk_sys);
        pulseCount = (cnt == 10'h000) ? 10'h001 : cnt;
        pulseCountWrite = 1'b1;
        @(negedge clk_sys);
        pulseCountWrite = 1'b0;
    endtask
    task automatic clear_irq();
        @(negedge clk_sys);
        interruptClearBit = 1'b1;
        @(negedge clk_sys);
        interruptClearBit = 1'b0;
    endtask
    // Reload well inside the guard span
    task automatic reload_guard();
        @(negedge clk_sys);
        watchdogReloadBit = 1'b1;
        @(negedge clk_sys);
        watchdogReloadBit = 1'b0;
    endtask
endmodule

/* File: tb_top.sv */
// Self-checking bench for the burst modulator and lockup guard
`timescale 1ns/1ps
module tb_top
    import irbm_pkg::*;
;
    logic          clk_sys = 1'b0;
    logic          reset = 1'b1;
    logic [7:0]    onTime, offTime, modDoneVector;
    logic [9:0]    pulseCount;
    logic          pulseCountWrite, interruptClearBit, watchdogReloadBit, stopMode;
    logic          pulseOut_n, modDoneIrq, guardReset;
    irbm_mode_type mode;
    int            miscompares = 0;
    int            checks_done = 0;
    always #12.5 clk_sys = ~clk_sys;
    irbm_core_model m (.clk_sys(clk_sys), .onTime(onTime), .offTime(offTime),
        .pulseCount(pulseCount), .pulseCountWrite(pulseCountWrite), .mode(mode),
        .interruptClearBit(interruptClearBit), .watchdogReloadBit(watchdogReloadBit),
        .stopMode(stopMode));
    localparam int GUARD_TB_STAGES = 6;
    localparam int GUARD_SPAN      = IRBM_GUARD_DIV * (1 << GUARD_TB_STAGES);
    // Short guard so overflow is reachable
    irbm_modulator #(.GUARD_STAGES(GUARD_TB_STAGES)) u_dut (.clk_sys(clk_sys), .reset(reset),
        .onTime(onTime), .offTime(offTime), .pulseCountLow(pulseCount[7:0]),
        .pulseCountHigh(pulseCount[9:8]), .pulseCountWrite(pulseCountWrite),
        .mode(mode), .interruptClearBit(interruptClearBit),
        .watchdogReloadBit(watchdogReloadBit), .stopMode(stopMode),
        .pulseOut_n(pulseOut_n), .modDoneIrq(modDoneIrq),
        .modDoneVector(modDoneVector), .guardReset(guardReset));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic check1(input string name, input logic got, input logic exp);
        checks_done++;
        if (got !== exp) begin
            $display("[FAIL] %s expected %b seen %b", name, exp, got);
            miscompares++;
        end
    endtask
    task automatic run_burst(input logic [7:0] on, off, input logic [9:0] cnt,
                             input logic [2:0] md);
        logic expQ[$];
        int   i, k;
        m.reload_guard();
        m.onTime = on;
        m.offTime = off;
        m.mode = irbm_mode_type'(md);
        for (i = 0; i < cnt; i++) begin
            for (k = 0; k < on + 2; k++) expQ.push_back(md[0] && (k % 4) >= 2);
            if (!md[1] && i < cnt - 1) for (k = 0; k < off + 2; k++) expQ.push_back(1'b1);
        end
        expQ.push_back(1'b1);
        m.load_count(cnt);
        check1("irq at write", modDoneIrq, 1'b0);
        foreach (expQ[j]) begin
            check1("pulseOut_n", pulseOut_n, expQ[j]);
            @(negedge clk_sys);
        end
        check1("done irq", modDoneIrq, 1'b1);
    endtask
    task automatic run_continuous();
        int i;
        m.onTime = 8'h00;
        m.offTime = 8'h00;
        m.mode = irbm_mode_type'(3'h4);
        m.load_count(10'h001);
        for (i = 0; i < 12; i++) begin
            check1("cont out", pulseOut_n, (i % 4) >= 2);
            @(negedge clk_sys);
        end
        check1("cont irq", modDoneIrq, 1'b0);
    endtask
    task automatic guard_check(input int stopLen);
        int n, s;
        n = 0;
        s = 0;
        m.reload_guard();
        while (guardReset !== 1'b1 && n < 2 * GUARD_SPAN) begin
            m.stopMode = (n == 200 && s < stopLen);
            @(negedge clk_sys);
            if (m.stopMode) s++;
            else n++;
        end
        m.stopMode = 1'b0;
        check1("guard span", n == GUARD_SPAN, 1'b1);
    endtask
    initial begin
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
        reset = 1'b0;
        check1("out at reset", pulseOut_n, 1'b1);
        check1("irq at reset", modDoneIrq, 1'b0);
        check1("vector", modDoneVector === 8'h05, 1'b1);
        m.onTime = 8'h07;
        repeat (6) @(negedge clk_sys);
        check1("no start", pulseOut_n, 1'b1);
        run_burst(8'h01, 8'h01, 10'h002, 3'h0);
        run_burst(8'h01, 8'h01, 10'h003, 3'h0);
        repeat (4) @(negedge clk_sys);
        check1("gap out", pulseOut_n, 1'b1);
        m.clear_irq();
        check1("irq cleared", modDoneIrq, 1'b0);
        run_burst(8'h05, 8'h00, 10'h002, 3'h1);
        run_burst(8'h01, 8'h03, 10'h003, 3'h2);
        run_burst(8'h00, 8'h00, 10'h101, 3'h0);
        run_continuous();
        run_burst(8'h02, 8'h02, 10'h001, 3'h0);
        guard_check(0);
        @(negedge clk_sys);
        check1("guard pulse", guardReset, 1'b0);
        check1("irq after guard", modDoneIrq, 1'b0);
        guard_check(500);
        @(negedge clk_sys);
        check1("dut guard", guardReset, 1'b0);
        tally_and_finish();
    end
    initial begin
        #500000;
        miscompares++;
        tally_and_finish();
    end
endmodule
